// File: intr_rx_pkg.sv
package intr_rx_pkg;
   // Widths of the bus CSR transaction fields.
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   // Broadcast space base and the two interrupt posting offsets.
   localparam logic [ADDR_W-1:0] BCAST_BASE = 32'hf000_0000;
   localparam logic [ADDR_W-1:0] IO_POST_OFS = 32'h0000_0000;
   localparam logic [ADDR_W-1:0] IPI_POST_OFS = 32'h0000_0040;
   localparam logic [ADDR_W-1:0] IO_POST_ADDR = BCAST_BASE + IO_POST_OFS;
   localparam logic [ADDR_W-1:0] IPI_POST_ADDR = BCAST_BASE + IPI_POST_OFS;
   // Level identification registers inside the I/O module, levels 0 to 3.
   localparam logic [ADDR_W-1:0] IDENT0_ADDR = 32'he000_0a00;
   localparam logic [ADDR_W-1:0] IDENT1_ADDR = 32'he000_0a40;
   localparam logic [ADDR_W-1:0] IDENT2_ADDR = 32'he000_0a80;
   localparam logic [ADDR_W-1:0] IDENT3_ADDR = 32'he000_0ac0;
   // Target layout: six CPUs, one four-bit nibble each.
   localparam int NUM_LVL = 4;
   localparam int NODE_W = 3;
   localparam logic [NODE_W-1:0] NUM_CPU = 3'h6;
   localparam logic [NODE_W-1:0] NODE_NONE = 3'h7;
   localparam logic [1:0] NIBBLE_LSB = 2'h0;
   // Pending counter per level.
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
   // Processor priority levels; level n maps to IPL_BASE + n.
   localparam int IPL_W = 5;
   localparam logic [IPL_W-1:0] IPL_BASE = 5'h14;
   localparam logic [IPL_W-1:0] IPL_NONE = 5'h00;

   // One bus CSR transaction as seen on the bus, valid for one cycle.
   typedef struct packed {
      logic wr;                 // CSR write command this cycle.
      logic rd;                 // CSR read command this cycle.
      logic [ADDR_W-1:0] addr;  // Target CSR address.
      logic [DATA_W-1:0] wdata; // Write data.
   } csr_req_s;
endpackage

// File: node_sync.sv
`timescale 1ns/1ns
// Three-stage synchroniser; the output moves only when stages two and
// three agree, which filters a single-cycle glitch on the pin.
module node_sync import intr_rx_pkg::*; #(
   parameter int W = 3,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic i_clk,         // Reference clock.
   input wire logic i_rst_n,       // Asynchronous reset, active low.
   input wire logic [W-1:0] i_d,   // Asynchronous input.
   output logic [W-1:0] o_q        // Filtered synchronous value.
);
   logic [W-1:0] s1_q; // First stage, read only by the second.
   logic [W-1:0] s2_q; // Second stage.
   logic [W-1:0] s3_q; // Third stage.
   logic [W-1:0] out_q; // Agreed value.
   logic [W-1:0] out_d; // Next agreed value.

   // The output follows only a value that has stood two cycles.
   always_comb begin
      out_d = out_q;
      if (s2_q == s3_q) begin
         out_d = s3_q;
      end
   end

   // Shift the stages and hold the agreed value.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
         out_q <= RST_VAL;
      end else begin
         s1_q <= i_d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         out_q <= out_d;
      end
   end

   assign o_q = out_q;
endmodule

// File: level_counter.sv
`timescale 1ns/1ns
// Pending count for one I/O interrupt level. A post and an acknowledge
// in the same cycle cancel, so no post is lost. The count saturates;
// posts beyond the maximum are dropped rather than wrapping to zero.
module level_counter import intr_rx_pkg::*; (
   input wire logic i_clk,              // Reference clock.
   input wire logic i_rst_n,            // Asynchronous reset, active low.
   input wire logic i_inc,              // One new post this cycle.
   input wire logic i_dec,              // One acknowledge this cycle.
   output logic [CNT_W-1:0] o_count     // Posts still pending.
);
   logic [CNT_W-1:0] cnt_q; // Current count.
   logic [CNT_W-1:0] cnt_d; // Next count.

   // Count up on a post, down on an acknowledge, hold on both.
   always_comb begin
      cnt_d = cnt_q;
      if (i_inc && !i_dec && cnt_q != CNT_MAX) begin
         cnt_d = cnt_q + CNT_ONE;
      end else if (i_dec && !i_inc && cnt_q != CNT_ZERO) begin
         cnt_d = cnt_q - CNT_ONE;
      end
   end

   // Register the count.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q <= CNT_ZERO;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign o_count = cnt_q;
endmodule

// File: intr_rx.sv
`timescale 1ns/1ns
// Overview of operation
// - Six CPU nibbles, CPU0 lowest, CPU5 bits 23:20.
// - Node examines only its own nibble.
// - Both registers accepted regardless of node ID.
// - Repeated ones post repeated interrupts; counted.
// - Reads of both locations are undefined.
// - Pending level asserts its request line.
// - Request lines become processor interrupt requests.
// - Levels 0 to 3 map to priority 20, 21, 22, 23.
// - Ident reads acknowledge; level0 read covers all.
// - Bits 5:0 select CPUs; 15:6 ignored.
// - Interprocessor bits are write-one-to-set.
// - Act only when own node bit set.
// - Interprocessor pulse lasts exactly one cycle; here it is high for every cycle that carries a selecting write.
// - Pulse ORed into processor interprocessor request.
module intr_rx import intr_rx_pkg::*; (
   input wire logic I_REF_CLK,               // Reference clock, 100 MHz.
   input wire logic I_RESETN,                // Asynchronous reset, low.
   input wire csr_req_s I_CSR_REQ,           // Bus CSR transaction.
   input wire logic [NODE_W-1:0] I_NODE_ID,  // Node ID strap pins.
   input wire logic [NUM_LVL-1:0] I_LVL_ACK, // Processor level acks.
   input wire logic I_IPI_OTHER,             // Other IPI request source.
   output logic [NUM_LVL-1:0] O_IO_LEVEL_REQ, // Level request lines.
   output logic [IPL_W-1:0] O_IPL,           // Highest requested INTERRUPT_PRIORITY_LEVEL.
   output logic O_IP_PULSE,                  // Interprocessor pulse.
   output logic O_PROC_IPI_REQ               // Processor IPI request.
);
   logic [NODE_W-1:0] node_id; // Filtered node identifier.
   logic node_ok; // Node identifier names one of the six targets.
   logic wr_io; // Write to the I/O posting location.
   logic wr_ipi; // Write to the interprocessor posting location.
   logic [NUM_LVL-1:0] own_bits; // This node's nibble of a post.
   logic [NUM_LVL-1:0] inc; // Per-level post this cycle.
   logic [NUM_LVL-1:0] ident_rd; // Per-level ident read this cycle.
   logic [NUM_LVL-1:0] dec; // Per-level acknowledge this cycle.
   logic ipi_hit; // This node selected by an interprocessor write.
   logic [NODE_W+1:0] nib_base; // Lowest bit of this node's nibble.
   logic ipi_own; // This node's bit of an interprocessor word.
   logic [CNT_W-1:0] cnt [NUM_LVL]; // Pending counts.
   logic [NUM_LVL-1:0] pend; // Levels with a nonzero count.
   logic [NUM_LVL-1:0] req_q; // Registered request lines.
   logic [NUM_LVL-1:0] req_d; // Next request lines.
   logic [IPL_W-1:0] ipl_q; // Registered priority level.
   logic [IPL_W-1:0] ipl_d; // Next priority level.
   logic ip_q; // Registered interprocessor pulse.
   logic ip_d; // Next interprocessor pulse.
   logic proc_q; // Registered processor IPI request.
   logic proc_d; // Next processor IPI request.

   // The strap may settle late, so it is filtered; until it has, the
   // node is none and no post is taken.
   node_sync #(
      .W(NODE_W),
      .RST_VAL(NODE_NONE)
   ) u_node_sync (
      .i_clk(I_REF_CLK),
      .i_rst_n(I_RESETN),
      .i_d(I_NODE_ID),
      .o_q(node_id)
   );

   // Decode the bus transaction. Broadcast writes match on address
   // alone, never on node ID. Reads of these locations get no answer
   // from this block; their data is undefined on the bus anyway.
   always_comb begin
      node_ok = (node_id < NUM_CPU);
      wr_io = I_CSR_REQ.wr && (I_CSR_REQ.addr == IO_POST_ADDR);
      wr_ipi = I_CSR_REQ.wr && (I_CSR_REQ.addr == IPI_POST_ADDR);
      // Node n's nibble starts at bit 4n, so the base is the node ID
      // with two zero bits below it.
      nib_base = {node_id, NIBBLE_LSB};
      own_bits = '0;
      if (node_ok) begin
         // Only this node's nibble is looked at; the rest is ignored.
         own_bits = I_CSR_REQ.wdata[nib_base +: NUM_LVL];
      end
      inc = wr_io ? own_bits : '0;
      // Bits 15:6 of the interprocessor word can never raise a hit, since
      // a valid node ID stops at five and node_ok gates the rest.
      ipi_own = I_CSR_REQ.wdata[node_id];
      ipi_hit = wr_ipi && node_ok && ipi_own;
   end

   // Ident reads aimed at the I/O module acknowledge a level; a level-0
   // ident read is handled as reads of all four levels.
   always_comb begin
      ident_rd = '0;
      if (I_CSR_REQ.rd) begin
         unique case (I_CSR_REQ.addr)
            IDENT0_ADDR: begin
               ident_rd = '1;
            end
            IDENT1_ADDR: begin
               ident_rd[1] = 1'b1;
            end
            IDENT2_ADDR: begin
               ident_rd[2] = 1'b1;
            end
            IDENT3_ADDR: begin
               ident_rd[3] = 1'b1;
            end
            default: begin
               // Reads of the posting locations land here: they are
               // neither answered nor acted on.
               ident_rd = '0;
            end
         endcase
      end
      dec = ident_rd | I_LVL_ACK;
   end

   // One pending counter per level.
   // A post and an acknowledge on one level in one cycle cancel there.
   for (genvar g = 0; g < NUM_LVL; g++) begin : g_lvl
      level_counter u_cnt (
         .i_clk(I_REF_CLK),
         .i_rst_n(I_RESETN),
         .i_inc(inc[g]),
         .i_dec(dec[g]),
         .o_count(cnt[g])
      );
      assign pend[g] = (cnt[g] != CNT_ZERO);
   end

   // Request lines and the priority level follow the pending counts;
   // the highest pending level wins the priority encoding.
   always_comb begin
      req_d = pend;
      ipl_d = IPL_NONE;
      for (int i = 0; i < NUM_LVL; i++) begin
         if (pend[i]) begin
            ipl_d = IPL_BASE + IPL_W'(i);
         end
      end
   end

   // Interprocessor pulse and the ORed processor request. A write held
   // on several cycles counts as one write per cycle.
   // The OR sits before the register so both outputs leave a flop.
   always_comb begin
      ip_d = ipi_hit;
      proc_d = ipi_hit | I_IPI_OTHER;
   end

   // Register every output.
   always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         req_q <= '0;
         ipl_q <= IPL_NONE;
         ip_q <= 1'b0;
         proc_q <= 1'b0;
      end else begin
         req_q <= req_d;
         ipl_q <= ipl_d;
         ip_q <= ip_d;
         proc_q <= proc_d;
      end
   end

   assign O_IO_LEVEL_REQ = req_q;
   assign O_IPL = ipl_q;
   assign O_IP_PULSE = ip_q;
   assign O_PROC_IPI_REQ = proc_q;

   // Checks on the receive logic.
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RESETN);

   // An acknowledge of the last pending post, then the line drops.
   sequence last_ack_s;
      cnt[0] == CNT_ONE && dec[0] && !inc[0];
   endsequence
   sequence line_drop_s;
      cnt[0] == CNT_ZERO ##1 !O_IO_LEVEL_REQ[0];
   endsequence

   chk_ipi_pulse_cause: assert property (
      O_IP_PULSE == $past(ipi_hit))
      else $error("IPI pulse not tied to a selecting write.");

   chk_ipi_single: assert property (
      (ipi_hit ##1 !ipi_hit) |=> !O_IP_PULSE)
      else $error("IPI pulse longer than one cycle.");

   chk_ipi_own_bit: assert property (
      (wr_ipi && !I_CSR_REQ.wdata[node_id]) |=> !O_IP_PULSE)
      else $error("IPI pulse without own node bit.");

   chk_proc_or: assert property (
      $past(I_IPI_OTHER) |-> O_PROC_IPI_REQ)
      else $error("Other IPI source not passed to processor.");

   chk_other_nibble: assert property (
      (wr_io && own_bits == '0 && dec == '0) |=> $stable(cnt[0]))
      else $error("Count moved on a write for another target.");

   chk_post_counts: assert property (
      (inc[1] && !dec[1] && cnt[1] != CNT_MAX)
      |=> cnt[1] == $past(cnt[1]) + CNT_ONE)
      else $error("Repeated post not counted.");

   chk_ident0_all: assert property (
      (I_CSR_REQ.rd && I_CSR_REQ.addr == IDENT0_ADDR) |-> dec == '1)
      else $error("Level-0 ident read did not cover all levels.");

   chk_req_follow: assert property (
      (cnt[2] != CNT_ZERO) |=> O_IO_LEVEL_REQ[2])
      else $error("Pending level without request line.");

   chk_ipl_top: assert property (
      pend[3] |=> O_IPL == IPL_BASE + IPL_W'(3))
      else $error("Top level not at priority 23.");

   chk_ack_drop: assert property (
      last_ack_s |=> line_drop_s)
      else $error("Request line held after last acknowledge.");

   // The remaining checks pin down the mapping and the
   // interprocessor path one property at a time, so that a
   // failure names the rule that broke rather than a symptom.

   // A selecting interprocessor write, stated from the bus
   // fields rather than from the decoded hit signal.
   sequence ipi_sel_s;
      wr_ipi && node_ok && I_CSR_REQ.wdata[node_id];
   endsequence

   // An empty level must leave its line low on the next cycle.
   chk_req_low: assert property (
      (cnt[1] == CNT_ZERO) |=> !O_IO_LEVEL_REQ[1])
      else $error("Empty level left its request line high.");

   // A post reaches the line two cycles later: one cycle to count,
   // one to register the line.
   chk_count_rise: assert property (
      (inc[0] && !dec[0]) |=> ##1 O_IO_LEVEL_REQ[0])
      else $error("Post did not raise its request line.");

   // With nothing pending the processor sees no request level.
   chk_ipl_idle: assert property (
      (pend == '0) |=> O_IPL == IPL_NONE)
      else $error("Priority level shown with nothing pending.");

   // Level 0 alone maps to priority 20.
   chk_ipl_base: assert property (
      (pend == 4'h1) |=> O_IPL == IPL_BASE)
      else $error("Level 0 not at priority 20.");

   // Level 1 wins over level 0 and maps to priority 21.
   chk_ipl_two: assert property (
      (pend[3:1] == 3'b001) |=> O_IPL == IPL_BASE + IPL_W'(1))
      else $error("Level 1 not at priority 21.");

   // Level 2 wins over the lower two and maps to priority 22.
   chk_ipl_mid: assert property (
      (pend[3:2] == 2'b01) |=> O_IPL == IPL_BASE + IPL_W'(2))
      else $error("Level 2 not at priority 22.");

   // A level-2 ident read acknowledges level 2; a missing decode here
   // would leave that level pending for ever.
   chk_ident_single: assert property (
      (I_CSR_REQ.rd && I_CSR_REQ.addr == IDENT2_ADDR) |-> dec[2])
      else $error("Level-2 ident read did not acknowledge.");

   // A read of any location must neither post nor pulse, because the
   // posting registers only take writes.
   chk_read_inert: assert property (
      (I_CSR_REQ.rd && !I_CSR_REQ.wr) |-> (inc == '0 && !ipi_hit))
      else $error("Read acted as a post.");

   // A post and an acknowledge in one cycle leave the count as it was,
   // so neither is lost.
   chk_post_cancel: assert property (
      (inc[3] && dec[3]) |=> $stable(cnt[3]))
      else $error("Post and acknowledge in one cycle moved the count.");

   // A write naming this node must produce the pulse.
   chk_ipi_hit: assert property (
      ipi_sel_s |=> O_IP_PULSE)
      else $error("Selecting write gave no pulse.");

   // The same write must reach the processor request as well.
   chk_proc_hit: assert property (
      ipi_sel_s |=> O_PROC_IPI_REQ)
      else $error("Selecting write missed the processor request.");

   // No selecting write, no pulse: the pulse never outlives its write
   // by a cycle.
   chk_pulse_low: assert property (
      !ipi_hit |=> !O_IP_PULSE)
      else $error("Pulse without a selecting write.");

   // A write with none of the node bits set must not pulse, since node
   // IDs stop at five and the upper bits are unused.
   chk_ipi_unused: assert property (
      (wr_ipi && I_CSR_REQ.wdata[5:0] == 6'h00) |=> !O_IP_PULSE)
      else $error("Unused interprocessor bits gave a pulse.");
endmodule

// File: bus_agent_model.sv
`timescale 1ns/1ns
// Stand-in for the I/O module and the peer CPUs on the shared bus.
module bus_agent_model import intr_rx_pkg::*; (
   input wire logic i_clk, // Bus clock; requests launch on its fall.
   output csr_req_s o_req  // CSR transaction seen by the receiver.
);
   // The bus starts idle, with no command.
   initial begin
      o_req = '0;
   end
   // One CSR command held for n cycles, then the bus is let go.
   task automatic xfer(input logic wr, input logic rd,
         input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data,
         input int n);
      @(negedge i_clk);
      o_req.wr = wr;
      o_req.rd = rd;
      o_req.addr = addr;
      o_req.wdata = {8'h00, data[23:0]};
      repeat (n) @(negedge i_clk);
      // A released bus holds nothing useful, so stale values are inverted.
      o_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
   endtask
   // The I/O module posts levels to one or many CPUs in one write.
   task automatic post_io(input logic [DATA_W-1:0] d, input int n);
      xfer(1'b1, 1'b0, IO_POST_ADDR, d, n);
   endtask
   // A peer CPU sets the destination bits of its interprocessor request.
   task automatic post_ipi(input logic [15:0] m);
      xfer(1'b1, 1'b0, IPI_POST_ADDR, {16'h0000, m}, 1);
   endtask
   // A read carries no write data; its answer is not relied upon.
   task automatic rd(input logic [ADDR_W-1:0] a);
      xfer(1'b0, 1'b1, a, '0, 1);
   endtask
endmodule

// File: bus_io_and_ipi_interrupt_receiver_test.sv
`timescale 1ns/1ns
module bus_io_and_ipi_interrupt_receiver_test;
   import intr_rx_pkg::*;
   logic ref_clk = 1'b0; // Reference clock.
   logic resetn = 1'b0; // Reset, active low.
   csr_req_s csr_req; // Bus transaction from the model.
   logic [NODE_W-1:0] node_id = 3'h2; // Node strap.
   logic [NUM_LVL-1:0] lvl_ack = 4'h0; // Processor acknowledges.
   logic ipi_other = 1'b0; // Other interprocessor source.
   logic [NUM_LVL-1:0] level_req; // Level request lines.
   logic [IPL_W-1:0] interrupt_priority_level; // Requested priority.
   logic ip_pulse; // Interprocessor pulse.
   logic proc_ipi_req; // Processor interprocessor request.
   int bad_count = 0; // Mismatches.
   int cmp_count = 0; // Comparisons.
   logic [ADDR_W-1:0] ident [4] = '{IDENT0_ADDR, IDENT1_ADDR, IDENT2_ADDR,
      IDENT3_ADDR}; // Level identification addresses.
   // Free-running 100 MHz clock.
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   bus_agent_model agent_u (.i_clk(ref_clk), .o_req(csr_req));
   intr_rx dut_u (.I_REF_CLK(ref_clk), .I_RESETN(resetn),
      .I_CSR_REQ(csr_req), .I_NODE_ID(node_id), .I_LVL_ACK(lvl_ack),
      .I_IPI_OTHER(ipi_other), .O_IO_LEVEL_REQ(level_req), .O_IPL(interrupt_priority_level),
      .O_IP_PULSE(ip_pulse), .O_PROC_IPI_REQ(proc_ipi_req));
   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Lets the count and line registers settle for a cycle, waits at most
   // four more cycles for the lines, then judges lines and level.
   task automatic expect_lvl(input logic [NUM_LVL-1:0] r,
         input logic [IPL_W-1:0] l);
      @(negedge ref_clk);
      for (int i = 0; i < 4 && level_req !== r; i++) @(negedge ref_clk);
      cmp_count++;
      if (level_req !== r || interrupt_priority_level !== l) begin
         bad_count++;
         $display("unexpected at %0t: lines %h level %h", $time,
            level_req, interrupt_priority_level);
      end
   endtask
   // Counts pulse cycles over a four-cycle window after a write.
   task automatic expect_pulse(input int n);
      int seen = 0;
      int req = 0;
      repeat (4) begin
         seen += int'(ip_pulse === 1'b1);
         req += int'(proc_ipi_req === 1'b1);
         @(negedge ref_clk);
      end
      cmp_count++;
      if (seen != n || req != n) begin
         bad_count++;
         $display("unexpected at %0t: pulse cycles %0d", $time, seen);
      end
   endtask
   // Raises an acknowledge mask at the next falling edge for n cycles.
   task automatic ack(input logic [NUM_LVL-1:0] m, input int n);
      @(negedge ref_clk);
      lvl_ack = m;
      repeat (n) @(negedge ref_clk);
      lvl_ack = 4'h0;
   endtask
   // Each level alone in the own nibble, all other nibbles full of noise.
   task automatic s_targeting();
      logic [23:0] d;
      for (int k = 0; k < 4; k++) begin
         d = 24'hffffff & ~(24'hf << (4 * node_id));
         d = d | (24'h1 << (4 * node_id + k));
         agent_u.post_io({8'h00, d}, 1);
         expect_lvl(4'h1 << k, IPL_BASE + 5'(k));
         agent_u.rd(ident[k]);
         expect_lvl(4'h0, IPL_NONE);
      end
   endtask
   // Three back-to-back posts, then a post and an acknowledge in one
   // cycle that must cancel, so three acknowledges clear the level.
   task automatic s_count();
      agent_u.post_io(32'h8 << (4 * node_id), 3);
      agent_u.rd(IO_POST_ADDR);
      fork
         agent_u.post_io(32'h8 << (4 * node_id), 1);
         ack(4'h8, 1);
      join
      ack(4'h8, 2);
      expect_lvl(4'h8, IPL_BASE + 5'h3);
      ack(4'h8, 1);
      expect_lvl(4'h0, IPL_NONE);
   endtask
   // All levels pending; one ident read, then the level-0 read clears all.
   task automatic s_ident0();
      agent_u.post_io(32'hf << (4 * node_id), 1);
      expect_lvl(4'hf, IPL_BASE + 5'h3);
      agent_u.rd(IDENT1_ADDR);
      expect_lvl(4'hd, IPL_BASE + 5'h3);
      agent_u.rd(IDENT0_ADDR);
      expect_lvl(4'h0, IPL_NONE);
   endtask
   // Foreign, unused and zero bits do nothing; the own bit pulses once.
   task automatic s_ipi();
      agent_u.post_ipi(16'hffff & ~(16'h1 << node_id));
      expect_pulse(0);
      agent_u.post_ipi(16'h0000);
      expect_pulse(0);
      agent_u.post_ipi(16'hffc0);
      expect_pulse(0);
      agent_u.post_ipi(16'h1 << node_id);
      expect_pulse(1);
      ipi_other = 1'b1;
      @(negedge ref_clk);
      ipi_other = 1'b0;
      cmp_count++;
      if (proc_ipi_req !== 1'b1 || ip_pulse !== 1'b0) begin
         bad_count++;
         $display("unexpected at %0t: other request not passed", $time);
      end
   endtask
   // A different node accepts the same broadcast locations.
   task automatic s_node();
      node_id = 3'h5;
      repeat (8) @(negedge ref_clk);
      agent_u.post_io(32'h0000_0f00, 1);
      expect_lvl(4'h0, IPL_NONE);
      agent_u.post_io(32'h0040_0000, 1);
      expect_lvl(4'h4, IPL_BASE + 5'h2);
      ack(4'h4, 1);
      expect_lvl(4'h0, IPL_NONE);
      agent_u.post_ipi(16'h0020);
      expect_pulse(1);
   endtask
   // Main sequence; the strap needs a few cycles after reset to settle.
   initial begin
      repeat (10) @(negedge ref_clk);
      resetn = 1'b1;
      repeat (8) @(negedge ref_clk);
      s_targeting();
      s_count();
      s_ident0();
      s_ipi();
      s_node();
      end_of_test();
   end
endmodule
